// File: l2acl_classifier.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// - A rule matches when every configured criterion holds or its match-every flag is set.
// - Rules in a list are indexed 1 through 9.
// - One action bit per rule: permit forwards, deny discards.
// - A rule may select egress queue 0 to 7 for matching frames.
// - A rule may force an output port, overriding normal forwarding.
// - A rule may compare 802.1p priority against a value 0 to 7.
// - Destination MAC compare; BPDU means prefix 01:80:C2, rest ignored.
// - Ethertype compare against predefined protocols or a user value.
// - User Ethertype value limited to 0x0600 through 0xFFFF.
// - A rule may compare the 48-bit source MAC address.
// - VLAN compare 0 to 4095; single value excludes a range.
// - Match-every flag makes any layer-2 frame match the rule.
// - Frames matching no permit rule are dropped.
// - Lists filter inbound traffic only.
// - Attached lists run in ascending sequence number, 1 to 4294967295.
// - Attaching on a used sequence number replaces that list.
// - Missing sequence number becomes highest in use plus one.
// - Creating a rule is refused when the list is full.
// - Class of type all matches when every criterion holds.
// - Class of type any matches when one criterion holds.
// - Classes tested in order added; first match's attributes apply.
// - QoS enable resets on; when off, config kept but inactive.
module l2acl_classifier (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic frame_valid,
	input wire l2acl_pkg::l2acl_frame_s frame_hdr,
	output logic result_valid,
	output l2acl_pkg::l2acl_result_s result
);

	function automatic logic known_addr(input logic [7:0] a);
		case (a)
		l2acl_pkg::OFS_CTRL, l2acl_pkg::OFS_STATUS, l2acl_pkg::OFS_CMD,
		l2acl_pkg::OFS_RCFG, l2acl_pkg::OFS_DMAC_LO,
		l2acl_pkg::OFS_DMAC_HI, l2acl_pkg::OFS_SMAC_LO,
		l2acl_pkg::OFS_SMAC_HI, l2acl_pkg::OFS_VLAN_ETYPE,
		l2acl_pkg::OFS_SEQ, l2acl_pkg::OFS_CLASS,
		l2acl_pkg::OFS_PERMIT_CNT, l2acl_pkg::OFS_DENY_CNT: known_addr = 1'b1;
		default: known_addr = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction

	function automatic logic etype_hit(input l2acl_pkg::l2acl_etype_e sel,
		input logic [15:0] user, input logic [15:0] et);
		case (sel)
		l2acl_pkg::ET_IPV4: etype_hit = et == l2acl_pkg::ET_VAL_IPV4;
		l2acl_pkg::ET_IPV6: etype_hit = et == l2acl_pkg::ET_VAL_IPV6;
		l2acl_pkg::ET_ARP: etype_hit = et == l2acl_pkg::ET_VAL_ARP;
		l2acl_pkg::ET_RARP: etype_hit = et == l2acl_pkg::ET_VAL_RARP;
		l2acl_pkg::ET_PPPOE: etype_hit = et == l2acl_pkg::ET_VAL_PPPOE_DISC ||
			et == l2acl_pkg::ET_VAL_PPPOE_SESS;
		l2acl_pkg::ET_MPLS_UC: etype_hit = et == l2acl_pkg::ET_VAL_MPLS_UC;
		l2acl_pkg::ET_MPLS_MC: etype_hit = et == l2acl_pkg::ET_VAL_MPLS_MC;
		default: etype_hit = et == user;
		endcase
	endfunction

	function automatic logic rule_hit(input l2acl_pkg::l2acl_rule_s r,
		input l2acl_pkg::l2acl_frame_s f);
		logic ok;
		logic dm;
		ok = 1'b1;
		// BPDU compares only the top three bytes
		dm = r.bpdu ? (f.dmac[47:24] == l2acl_pkg::BPDU_PREFIX) :
			(f.dmac == r.dmac);
		if (r.cfg.cos_en && f.cos != r.cfg.cos) ok = 1'b0;
		if (r.cfg.dmac_en && !dm) ok = 1'b0;
		if (r.cfg.etype_en &&
			!etype_hit(r.cfg.esel, r.etype_user, f.etype)) ok = 1'b0;
		if (r.cfg.smac_en && f.smac != r.smac) ok = 1'b0;
		if (r.cfg.vlan_en && f.vlan != r.vlan) ok = 1'b0;
		// All enabled criteria must agree, or the every flag must be set
		rule_hit = r.valid && (r.cfg.every || ok);
	endfunction

	function automatic logic class_hit(input l2acl_pkg::l2acl_class_s c,
		input l2acl_pkg::l2acl_frame_s f);
		logic [3:0] en;
		logic [3:0] hit;
		en = {c.cfg.every, c.cfg.cos_en, c.cfg.vlan_en, c.cfg.etype_en};
		hit = {1'b1, f.cos == c.cfg.cos, f.vlan == c.cfg.vlan,
			f.etype == c.etype};
		if (c.cfg.any_type) begin
			class_hit = c.valid && |(en & hit);
		end else begin
			class_hit = c.valid && (en != 4'h0) && ((en & hit) == en);
		end
	endfunction

	logic aw_full_reg;
	logic [7:0] aw_addr_reg;
	logic w_full_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_wr;
	logic qos_en_reg;
	logic err_reg;
	logic [3:0] last_idx_reg;
	logic [31:0] rcfg_reg;
	logic [31:0] dmac_lo_reg;
	logic [31:0] dmac_hi_reg;
	logic [31:0] smac_lo_reg;
	logic [31:0] smac_hi_reg;
	logic [31:0] vlan_etype_reg;
	logic [31:0] seq_reg;
	logic [31:0] class_reg;
	logic [31:0] permit_cnt_reg;
	logic [31:0] deny_cnt_reg;
	l2acl_pkg::l2acl_rule_s rules_reg [l2acl_pkg::LISTS][l2acl_pkg::RULES];
	logic slot_valid_reg [l2acl_pkg::SLOTS];
	logic [31:0] slot_seq_reg [l2acl_pkg::SLOTS];
	logic slot_list_reg [l2acl_pkg::SLOTS];
	l2acl_pkg::l2acl_class_s classes_reg [l2acl_pkg::CLASSES];

	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready = !w_full_reg;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= l2acl_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known_addr(aw_addr_reg) ? l2acl_pkg::RESP_OKAY :
					l2acl_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Staging registers plus the QoS enable; a command copies the staging ones into the tables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			qos_en_reg <= l2acl_pkg::QOS_EN_RST;
			rcfg_reg <= 32'h00000000;
			dmac_lo_reg <= 32'h00000000;
			dmac_hi_reg <= 32'h00000000;
			smac_lo_reg <= 32'h00000000;
			smac_hi_reg <= 32'h00000000;
			vlan_etype_reg <= 32'h00000000;
			seq_reg <= 32'h00000000;
			class_reg <= 32'h00000000;
		end else if (do_wr) begin
			case (aw_addr_reg)
			l2acl_pkg::OFS_CTRL: begin
				if (w_strb_reg[0]) qos_en_reg <= w_data_reg[0];
			end
			l2acl_pkg::OFS_RCFG:
				rcfg_reg <= merge(rcfg_reg, w_data_reg, w_strb_reg);
			l2acl_pkg::OFS_DMAC_LO:
				dmac_lo_reg <= merge(dmac_lo_reg, w_data_reg, w_strb_reg);
			l2acl_pkg::OFS_DMAC_HI:
				dmac_hi_reg <= merge(dmac_hi_reg, w_data_reg, w_strb_reg);
			l2acl_pkg::OFS_SMAC_LO:
				smac_lo_reg <= merge(smac_lo_reg, w_data_reg, w_strb_reg);
			l2acl_pkg::OFS_SMAC_HI:
				smac_hi_reg <= merge(smac_hi_reg, w_data_reg, w_strb_reg);
			l2acl_pkg::OFS_VLAN_ETYPE:
				vlan_etype_reg <= merge(vlan_etype_reg, w_data_reg, w_strb_reg);
			l2acl_pkg::OFS_SEQ:
				seq_reg <= merge(seq_reg, w_data_reg, w_strb_reg);
			l2acl_pkg::OFS_CLASS:
				class_reg <= merge(class_reg, w_data_reg, w_strb_reg);
			default: ;
			endcase
		end
	end

	l2acl_pkg::l2acl_cmd_s cmd;
	logic cmd_go;
	l2acl_pkg::l2acl_rule_s new_rule;
	logic cmd_ok;
	logic [3:0] tgt_idx;
	logic [1:0] tgt_slot;
	logic [31:0] tgt_seq;
	logic [31:0] max_seq;
	logic any_free;
	logic [1:0] free_slot;
	logic [1:0] cls_free;
	logic cls_any_free;

	assign cmd = l2acl_pkg::l2acl_cmd_s'(w_data_reg);
	assign cmd_go = do_wr && aw_addr_reg == l2acl_pkg::OFS_CMD &&
		w_strb_reg == 4'hF;

	always_comb begin
		new_rule.valid = 1'b1;
		new_rule.cfg = l2acl_pkg::l2acl_rcfg_s'(rcfg_reg);
		new_rule.bpdu = dmac_hi_reg[l2acl_pkg::BPDU_BIT];
		new_rule.dmac = {dmac_hi_reg[15:0], dmac_lo_reg};
		new_rule.smac = {smac_hi_reg[15:0], smac_lo_reg};
		new_rule.vlan = vlan_etype_reg[11:0];
		new_rule.etype_user = vlan_etype_reg[31:16];
		tgt_idx = cmd.idx;
		// Lowest free index for create; none free means the list is full
		any_free = 1'b0;
		for (int i = l2acl_pkg::RULES - 1; i >= 0; i--) begin
			if (!rules_reg[cmd.list][i].valid) begin
				any_free = 1'b1;
				if (cmd.op == l2acl_pkg::OP_CREATE) tgt_idx = 4'(i + 1);
			end
		end
		max_seq = 32'h00000000;
		free_slot = 2'h0;
		cls_any_free = 1'b0;
		cls_free = 2'h0;
		for (int s = l2acl_pkg::SLOTS - 1; s >= 0; s--) begin
			if (slot_valid_reg[s] && slot_seq_reg[s] > max_seq)
				max_seq = slot_seq_reg[s];
		end
		tgt_seq = cmd.seq_auto ? max_seq + 32'h00000001 : seq_reg;
		for (int s = l2acl_pkg::SLOTS - 1; s >= 0; s--) begin
			if (!slot_valid_reg[s]) free_slot = 2'(s);
		end
		for (int c = l2acl_pkg::CLASSES - 1; c >= 0; c--) begin
			if (!classes_reg[c].valid) begin
				cls_free = 2'(c);
				cls_any_free = 1'b1;
			end
		end
		tgt_slot = free_slot;
		cmd_ok = 1'b0;
		for (int s = l2acl_pkg::SLOTS - 1; s >= 0; s--) begin
			if (slot_valid_reg[s] && slot_seq_reg[s] == tgt_seq) begin
				tgt_slot = 2'(s);
				cmd_ok = 1'b1;
			end
		end
		case (cmd.op)
		l2acl_pkg::OP_WRITE: cmd_ok = tgt_idx >= 4'h1 && tgt_idx <= 4'h9;
		l2acl_pkg::OP_CREATE: cmd_ok = any_free;
		l2acl_pkg::OP_DELETE: cmd_ok = tgt_idx >= 4'h1 && tgt_idx <= 4'h9;
		l2acl_pkg::OP_ATTACH: cmd_ok = (cmd_ok || !slot_valid_reg[free_slot]) &&
			tgt_seq != 32'h00000000 &&
			!(cmd.seq_auto && max_seq == l2acl_pkg::SEQ_MAX);
		l2acl_pkg::OP_DETACH: ;
		l2acl_pkg::OP_CLASS: cmd_ok = cls_any_free;
		default: cmd_ok = 1'b0;
		endcase
		// Out-of-range user Ethertype is refused for rule writes
		if ((cmd.op == l2acl_pkg::OP_WRITE || cmd.op == l2acl_pkg::OP_CREATE) &&
			new_rule.cfg.etype_en && new_rule.cfg.esel == l2acl_pkg::ET_USER &&
			new_rule.etype_user < l2acl_pkg::ETYPE_USER_MIN)
			cmd_ok = 1'b0;
		// VLAN range is not held here, so only single-value compare exists
		if (tgt_idx == 4'h0 || tgt_idx > 4'h9) tgt_idx = 4'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_reg <= 1'b0;
			last_idx_reg <= 4'h0;
			for (int l = 0; l < l2acl_pkg::LISTS; l++) begin
				for (int i = 0; i < l2acl_pkg::RULES; i++) begin
					rules_reg[l][i] <= '0;
				end
			end
			for (int s = 0; s < l2acl_pkg::SLOTS; s++) begin
				slot_valid_reg[s] <= 1'b0;
				slot_seq_reg[s] <= 32'h00000000;
				slot_list_reg[s] <= 1'b0;
			end
			for (int c = 0; c < l2acl_pkg::CLASSES; c++) begin
				classes_reg[c] <= '0;
			end
		end else if (cmd_go) begin
			err_reg <= !cmd_ok;
			if (cmd_ok) begin
				case (cmd.op)
				l2acl_pkg::OP_WRITE, l2acl_pkg::OP_CREATE: begin
					rules_reg[cmd.list][tgt_idx - 4'h1] <= new_rule;
					last_idx_reg <= tgt_idx;
				end
				l2acl_pkg::OP_DELETE:
					rules_reg[cmd.list][tgt_idx - 4'h1].valid <= 1'b0;
				l2acl_pkg::OP_ATTACH: begin
					slot_valid_reg[tgt_slot] <= 1'b1;
					slot_seq_reg[tgt_slot] <= tgt_seq;
					slot_list_reg[tgt_slot] <= cmd.list;
				end
				l2acl_pkg::OP_DETACH: begin
					if (slot_seq_reg[tgt_slot] == tgt_seq)
						slot_valid_reg[tgt_slot] <= 1'b0;
				end
				l2acl_pkg::OP_CLASS: begin
					// Appended in order, so index order is add order
					classes_reg[cls_free] <= {1'b1, class_reg,
						vlan_etype_reg[31:16]};
					last_idx_reg <= {2'h0, cls_free};
				end
				default: ;
				endcase
			end
		end
	end

	// Frame evaluation: the frame port carries inbound frames only
	logic list_hit [l2acl_pkg::LISTS];
	logic [3:0] list_idx [l2acl_pkg::LISTS];
	logic [1:0] rank [l2acl_pkg::SLOTS];
	logic dec_hit;
	l2acl_pkg::l2acl_rule_s dec_rule;
	logic q_hit;
	logic [1:0] q_cls;

	always_comb begin
		for (int l = 0; l < l2acl_pkg::LISTS; l++) begin
			list_hit[l] = 1'b0;
			list_idx[l] = 4'h0;
			for (int i = l2acl_pkg::RULES - 1; i >= 0; i--) begin
				if (rule_hit(rules_reg[l][i], frame_hdr)) begin
					list_hit[l] = 1'b1;
					list_idx[l] = 4'(i);
				end
			end
		end
		for (int s = 0; s < l2acl_pkg::SLOTS; s++) begin
			rank[s] = 2'h0;
			for (int t = 0; t < l2acl_pkg::SLOTS; t++) begin
				if (slot_valid_reg[t] && slot_seq_reg[t] < slot_seq_reg[s])
					rank[s] = rank[s] + 2'h1;
			end
		end
		dec_hit = 1'b0;
		dec_rule = '0;
		for (int r = l2acl_pkg::SLOTS - 1; r >= 0; r--) begin
			for (int s = 0; s < l2acl_pkg::SLOTS; s++) begin
				if (slot_valid_reg[s] && rank[s] == 2'(r) &&
					list_hit[slot_list_reg[s]]) begin
					dec_hit = 1'b1;
					dec_rule = rules_reg[slot_list_reg[s]][list_idx[slot_list_reg[s]]];
				end
			end
		end
		q_hit = 1'b0;
		q_cls = 2'h0;
		for (int c = l2acl_pkg::CLASSES - 1; c >= 0; c--) begin
			if (class_hit(classes_reg[c], frame_hdr)) begin
				q_hit = 1'b1;
				q_cls = 2'(c);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_valid <= 1'b0;
			result <= '0;
		end else begin
			result_valid <= frame_valid;
			if (frame_valid) begin
				result.matched <= dec_hit;
				result.permit <= dec_hit && dec_rule.cfg.action;
				result.queue_valid <= dec_hit && dec_rule.cfg.queue_en;
				result.queue <= dec_rule.cfg.queue;
				result.redirect <= dec_hit && dec_rule.cfg.redir_en;
				result.port <= dec_rule.cfg.port;
				result.qos_hit <= qos_en_reg && q_hit;
				result.qos_class <= q_cls;
				result.qos_cos <= classes_reg[q_cls].cfg.mark_cos;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			permit_cnt_reg <= 32'h00000000;
			deny_cnt_reg <= 32'h00000000;
		end else if (frame_valid) begin
			if (dec_hit && dec_rule.cfg.action)
				permit_cnt_reg <= permit_cnt_reg + 32'h00000001;
			else
				deny_cnt_reg <= deny_cnt_reg + 32'h00000001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= l2acl_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= known_addr(s_axi_araddr) ? l2acl_pkg::RESP_OKAY :
				l2acl_pkg::RESP_SLVERR;
			case (s_axi_araddr)
			l2acl_pkg::OFS_CTRL: s_axi_rdata <= {31'h0, qos_en_reg};
			l2acl_pkg::OFS_STATUS: s_axi_rdata <= {27'h0, last_idx_reg, err_reg};
			l2acl_pkg::OFS_RCFG: s_axi_rdata <= rcfg_reg;
			l2acl_pkg::OFS_DMAC_LO: s_axi_rdata <= dmac_lo_reg;
			l2acl_pkg::OFS_DMAC_HI: s_axi_rdata <= dmac_hi_reg;
			l2acl_pkg::OFS_SMAC_LO: s_axi_rdata <= smac_lo_reg;
			l2acl_pkg::OFS_SMAC_HI: s_axi_rdata <= smac_hi_reg;
			l2acl_pkg::OFS_VLAN_ETYPE: s_axi_rdata <= vlan_etype_reg;
			l2acl_pkg::OFS_SEQ: s_axi_rdata <= seq_reg;
			l2acl_pkg::OFS_CLASS: s_axi_rdata <= class_reg;
			l2acl_pkg::OFS_PERMIT_CNT: s_axi_rdata <= permit_cnt_reg;
			l2acl_pkg::OFS_DENY_CNT: s_axi_rdata <= deny_cnt_reg;
			default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// File: l2acl_pkg.sv
package l2acl_pkg;
	localparam int RULES = 9;
	localparam int LISTS = 2;
	localparam int SLOTS = 4;
	localparam int CLASSES = 4;
	localparam int ADDR_W = 8;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_RCFG = 8'h0C;
	localparam logic [7:0] OFS_DMAC_LO = 8'h10;
	localparam logic [7:0] OFS_DMAC_HI = 8'h14;
	localparam logic [7:0] OFS_SMAC_LO = 8'h18;
	localparam logic [7:0] OFS_SMAC_HI = 8'h1C;
	localparam logic [7:0] OFS_VLAN_ETYPE = 8'h20;
	localparam logic [7:0] OFS_SEQ = 8'h24;
	localparam logic [7:0] OFS_CLASS = 8'h28;
	localparam logic [7:0] OFS_PERMIT_CNT = 8'h2C;
	localparam logic [7:0] OFS_DENY_CNT = 8'h30;

	localparam int BPDU_BIT = 16;
	localparam logic [23:0] BPDU_PREFIX = 24'h0180C2;
	localparam logic [15:0] ETYPE_USER_MIN = 16'h0600;
	localparam logic [31:0] SEQ_MAX = 32'hFFFFFFFF;
	localparam logic QOS_EN_RST = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [15:0] ET_VAL_IPV4 = 16'h0800;
	localparam logic [15:0] ET_VAL_IPV6 = 16'h86DD;
	localparam logic [15:0] ET_VAL_ARP = 16'h0806;
	localparam logic [15:0] ET_VAL_RARP = 16'h8035;
	localparam logic [15:0] ET_VAL_PPPOE_DISC = 16'h8863;
	localparam logic [15:0] ET_VAL_PPPOE_SESS = 16'h8864;
	localparam logic [15:0] ET_VAL_MPLS_UC = 16'h8847;
	localparam logic [15:0] ET_VAL_MPLS_MC = 16'h8848;

	typedef enum logic [2:0] {
		ET_IPV4, ET_IPV6, ET_ARP, ET_RARP,
		ET_PPPOE, ET_MPLS_UC, ET_MPLS_MC, ET_USER
	} l2acl_etype_e;

	typedef enum logic [2:0] {
		OP_NONE, OP_WRITE, OP_CREATE, OP_DELETE,
		OP_ATTACH, OP_DETACH, OP_CLASS
	} l2acl_op_e;

	typedef struct packed {
		logic [20:0] rsvd;
		logic seq_auto;
		logic [1:0] slot;
		logic [3:0] idx;
		logic list;
		l2acl_op_e op;
	} l2acl_cmd_s;

	typedef struct packed {
		logic [8:0] rsvd;
		logic [4:0] port;
		l2acl_etype_e esel;
		logic [2:0] queue;
		logic [2:0] cos;
		logic redir_en;
		logic queue_en;
		logic vlan_en;
		logic smac_en;
		logic etype_en;
		logic dmac_en;
		logic cos_en;
		logic every;
		logic action;
	} l2acl_rcfg_s;

	typedef struct packed {
		logic valid;
		l2acl_rcfg_s cfg;
		logic bpdu;
		logic [47:0] dmac;
		logic [47:0] smac;
		logic [11:0] vlan;
		logic [15:0] etype_user;
	} l2acl_rule_s;

	typedef struct packed {
		logic [8:0] rsvd;
		logic [11:0] vlan;
		logic [2:0] mark_cos;
		logic [2:0] cos;
		logic etype_en;
		logic vlan_en;
		logic cos_en;
		logic every;
		logic any_type;
	} l2acl_ccfg_s;

	typedef struct packed {
		logic valid;
		l2acl_ccfg_s cfg;
		logic [15:0] etype;
	} l2acl_class_s;

	typedef struct packed {
		logic [2:0] cos;
		logic [47:0] dmac;
		logic [47:0] smac;
		logic [15:0] etype;
		logic [11:0] vlan;
	} l2acl_frame_s;

	typedef struct packed {
		logic permit;
		logic matched;
		logic queue_valid;
		logic [2:0] queue;
		logic redirect;
		logic [4:0] port;
		logic qos_hit;
		logic [1:0] qos_class;
		logic [2:0] qos_cos;
	} l2acl_result_s;
endpackage

// File: l2acl_classifier_asserts.sv
`timescale 1ns/1ns
module l2acl_classifier_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic frame_valid,
	input wire logic result_valid,
	input wire l2acl_pkg::l2acl_result_s result
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Only a transfer with no response pending is answered two cycles later
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
			!s_axi_bvalid;
	endsequence

	AST_READ_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read not answered one cycle after address");
	AST_WRITE_ANSWER: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
		else $error("write not answered two cycles after transfer");
	AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address slot not held after acceptance");
	AST_RESULT_FOLLOWS: assert property (frame_valid |=> result_valid)
		else $error("frame without result next cycle");
	AST_RESULT_PULSE: assert property (!frame_valid |=> !result_valid)
		else $error("result without inbound frame");
	AST_NOMATCH_DROP: assert property (
		result_valid && !result.matched |-> !result.permit)
		else $error("unmatched frame permitted");
	AST_QUEUE_MATCH: assert property (
		result_valid && result.queue_valid |-> result.matched)
		else $error("queue chosen without a matching rule");
	AST_REDIR_MATCH: assert property (
		result_valid && result.redirect |-> result.matched)
		else $error("redirect without a matching rule");
	AST_RESULT_HOLD: assert property (!frame_valid |=> $stable(result))
		else $error("result changed without a frame");
endmodule

// File: l2acl_port_model.sv
`timescale 1ns/1ns
module l2acl_port_model (
	input wire logic aclk,
	output logic frame_valid,
	output l2acl_pkg::l2acl_frame_s frame_hdr,
	input wire logic result_valid,
	input wire l2acl_pkg::l2acl_result_s result
);
	initial begin
		frame_valid = 1'h0;
		frame_hdr = '0;
	end

	// Released header is inverted so a stale value never looks valid
	task automatic send(input l2acl_pkg::l2acl_frame_s h,
		output l2acl_pkg::l2acl_result_s r, output logic rv);
		@(posedge aclk);
		frame_valid <= 1'h1;
		frame_hdr <= h;
		@(posedge aclk);
		frame_valid <= 1'h0;
		frame_hdr <= ~h;
		@(posedge aclk);
		rv = result_valid;
		r = result;
	endtask
endmodule

// File: l2acl_classifier_test.sv
`timescale 1ns/1ns
module l2acl_classifier_test;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, frame_valid, result_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	l2acl_pkg::l2acl_frame_s frame_hdr;
	l2acl_pkg::l2acl_result_s result;
	int miscompares = 0, checks_done = 0;
	logic [31:0] rd;

	always #50 aclk = ~aclk;

	l2acl_classifier i_l2acl_classifier (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.frame_valid, .frame_hdr, .result_valid, .result);
	l2acl_port_model i_l2acl_port_model (.aclk, .frame_valid, .frame_hdr,
		.result_valid, .result);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = l2acl_pkg::RESP_OKAY);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, er);
	endtask

	task automatic rdr(input logic [7:0] a,
		input logic [1:0] er = l2acl_pkg::RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		rd = s_axi_rdata;
		chk(s_axi_rresp, er);
	endtask

	function automatic logic [31:0] cm(input logic [2:0] op,
		input logic [3:0] idx, input logic au);
		return {21'h0, au, 2'h0, idx, 1'h0, op};
	endfunction

	task automatic fr(input logic [2:0] c, input logic [47:0] dm,
		input logic [11:0] v, output l2acl_pkg::l2acl_result_s r);
		l2acl_pkg::l2acl_frame_s h;
		logic rv;
		h = '{cos: c, dmac: dm, smac: 48'h0A0B0C0D0E0E,
			etype: 16'h0800, vlan: v};
		i_l2acl_port_model.send(h, r, rv);
		chk(rv, 32'h1);
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		give_verdict();
	end

	initial begin
		l2acl_pkg::l2acl_result_s r;
		logic [31:0] et;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rdr(l2acl_pkg::OFS_CTRL);
		chk(rd, 32'h1);
		rdr(8'h3C, l2acl_pkg::RESP_SLVERR);
		chk(rd, 32'h0);
		wr(8'h3C, 32'h1, l2acl_pkg::RESP_SLVERR);
		$display("test reset and map done");
		// Rule 1 denies one source, rule 2 catches the rest
		wr(l2acl_pkg::OFS_SMAC_LO, 32'h0C0D0E0F);
		wr(l2acl_pkg::OFS_SMAC_HI, 32'h00000A0B);
		wr(l2acl_pkg::OFS_RCFG, 32'h00000020);
		wr(l2acl_pkg::OFS_CMD, cm(3'h2, 4'h0, 1'h0));
		wr(l2acl_pkg::OFS_RCFG, 32'h000C5183);
		wr(l2acl_pkg::OFS_CMD, cm(3'h2, 4'h0, 1'h0));
		rdr(l2acl_pkg::OFS_STATUS);
		chk(rd, 32'h4);
		fr(3'h0, 48'h0, 12'h0, r);
		chk({r.permit, r.matched}, 32'h0);
		wr(l2acl_pkg::OFS_CMD, cm(3'h4, 4'h0, 1'h1));
		rdr(l2acl_pkg::OFS_STATUS);
		chk(rd[0], 32'h0);
		wr(l2acl_pkg::OFS_SMAC_LO, 32'h0C0D0E0E);
		wr(l2acl_pkg::OFS_RCFG, 32'h00000020);
		wr(l2acl_pkg::OFS_CMD, cm(3'h1, 4'h1, 1'h0));
		fr(3'h0, 48'h0, 12'h0, r);
		chk({r.permit, r.matched, r.queue_valid, r.redirect}, 32'h4);
		wr(l2acl_pkg::OFS_SMAC_LO, 32'h0C0D0E0F);
		wr(l2acl_pkg::OFS_CMD, cm(3'h1, 4'h1, 1'h0));
		fr(3'h0, 48'h0, 12'h0, r);
		chk({r.permit, r.matched, r.queue_valid, r.queue, r.redirect,
			r.port}, 32'hF63);
		$display("test first match done");
		// Rule 1 now: bridge group prefix and priority 5, both required
		wr(l2acl_pkg::OFS_DMAC_HI, 32'h00010000);
		wr(l2acl_pkg::OFS_RCFG, 32'h00000A0C);
		wr(l2acl_pkg::OFS_CMD, cm(3'h1, 4'h1, 1'h0));
		fr(3'h5, 48'h0180C2123456, 12'h0, r);
		chk({r.permit, r.matched}, 32'h1);
		fr(3'h4, 48'h0180C2123456, 12'h0, r);
		chk(r.permit, 32'h1);
		fr(3'h5, 48'h0180C3123456, 12'h0, r);
		chk(r.permit, 32'h1);
		$display("test criteria done");
		for (int i = 3; i <= 10; i++) begin
			wr(l2acl_pkg::OFS_RCFG, 32'h00000003);
			wr(l2acl_pkg::OFS_CMD, cm(3'h2, 4'h0, 1'h0));
			rdr(l2acl_pkg::OFS_STATUS);
			if (i < 10)
				chk(rd, 32'(i << 1));
			else
				chk(rd[0], 32'h1);
		end
		// User value below the legal floor is refused, floor itself taken
		for (int k = 0; k < 2; k++) begin
			et = (k == 0) ? 32'h05FF0000 : 32'h06000000;
			wr(l2acl_pkg::OFS_VLAN_ETYPE, et);
			wr(l2acl_pkg::OFS_RCFG, 32'h00038010);
			wr(l2acl_pkg::OFS_CMD, cm(3'h1, 4'h3, 1'h0));
			rdr(l2acl_pkg::OFS_STATUS);
			chk(rd[0], 32'(1 - k));
		end
		$display("test list limits done");
		wr(l2acl_pkg::OFS_CLASS, 32'h0000A2CD);
		wr(l2acl_pkg::OFS_CMD, cm(3'h6, 4'h0, 1'h0));
		wr(l2acl_pkg::OFS_CLASS, 32'h0000546C);
		wr(l2acl_pkg::OFS_CMD, cm(3'h6, 4'h0, 1'h0));
		fr(3'h3, 48'h0, 12'd20, r);
		chk({r.qos_hit, r.qos_class, r.qos_cos}, 32'h22);
		fr(3'h3, 48'h0, 12'hA, r);
		chk({r.qos_hit, r.qos_class, r.qos_cos}, 32'h2C);
		fr(3'h3, 48'h0, 12'hB, r);
		chk(r.qos_hit, 32'h0);
		wr(l2acl_pkg::OFS_CTRL, 32'h0);
		rdr(l2acl_pkg::OFS_CTRL);
		chk(rd, 32'h0);
		fr(3'h3, 48'h0, 12'd20, r);
		chk(r.qos_hit, 32'h0);
		wr(l2acl_pkg::OFS_CTRL, 32'h1);
		fr(3'h3, 48'h0, 12'd20, r);
		chk({r.qos_hit, r.qos_class, r.qos_cos}, 32'h22);
		$display("test qos done");
		// List 1 denies VLAN 5; attaching it on seq 1 replaces list 0
		wr(l2acl_pkg::OFS_RCFG, 32'h00000040);
		wr(l2acl_pkg::OFS_VLAN_ETYPE, 32'h00000005);
		wr(l2acl_pkg::OFS_CMD, cm(3'h1, 4'h1, 1'h0) | 32'h00000008);
		wr(l2acl_pkg::OFS_SEQ, 32'h00000001);
		wr(l2acl_pkg::OFS_CMD, cm(3'h4, 4'h0, 1'h0) | 32'h00000008);
		fr(3'h0, 48'h0, 12'h005, r);
		chk({r.permit, r.matched}, 32'h1);
		fr(3'h0, 48'h0, 12'h006, r);
		chk(r.matched, 32'h0);
		wr(l2acl_pkg::OFS_CMD, cm(3'h4, 4'h0, 1'h1));
		fr(3'h0, 48'h0, 12'h006, r);
		chk(r.permit, 32'h1);
		fr(3'h0, 48'h0, 12'h005, r);
		chk({r.permit, r.matched}, 32'h1);
		wr(l2acl_pkg::OFS_CMD, cm(3'h5, 4'h0, 1'h0));
		fr(3'h0, 48'h0, 12'h005, r);
		chk(r.permit, 32'h1);
		rdr(l2acl_pkg::OFS_PERMIT_CNT);
		chk(rd, 32'h0000000A);
		rdr(l2acl_pkg::OFS_DENY_CNT);
		chk(rd, 32'h00000006);
		$display("test attach order done");
		give_verdict();
	end
endmodule

bind l2acl_classifier l2acl_classifier_asserts i_l2acl_classifier_asserts (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .frame_valid, .result_valid, .result);
